// ---- include/sbc_cfg_consts.svh ----
// Purpose: register indices, field positions, reset values and timing figures
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef SBC_CFG_CONSTS_SVH
`define SBC_CFG_CONSTS_SVH

// register indices
`define IDX_SWITCH_LOCK 6'h0f
`define IDX_PIN_FUNC 6'h17
`define IDX_PWM_DUTY 6'h18
`define IDX_SOFT_CTRL 6'h30
`define IDX_STATUS 6'h31

// switching and lock control fields
`define SWLK_POR 8'h40
`define SWLK_WMASK 8'hfd
`define FREQ_MSB 7
`define FREQ_LSB 5
`define FREQ_RSVD_BIT 7
`define PEAK_BIT 4
`define SS_MSB 3
`define SS_LSB 2
`define LOCK1_BIT 0

// pin function codes
`define PINF_POR 3'h0
`define PF_CYCLIC 3'h3
`define PF_OFF 3'h4
`define PF_WAKE 3'h5
`define PF_PWM_LS 3'h6
`define PF_PWM_HS 3'h7
`define PF_FAIL_MAX 3'h2

// duty setting
`define DUTY_POR 8'h00
`define DUTY_FULL 8'hff
`define PWM_CNT_MAX 8'hfe

// soft control and status bits
`define SOFT_RST_BIT 0
`define ST_LOCK1_BIT 0
`define ST_LOCK0_BIT 1
`define ST_VALID_BIT 2
`define ST_FAILSAFE_BIT 3
`define ST_PWM_BIT 4

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// timing
`define CLK_FREQ_KHZ 20000
`define EXT_RESET_DELAY_US 100
`define EXT_RESET_DELAY_CYC ((`EXT_RESET_DELAY_US * `CLK_FREQ_KHZ) / 1000)

// synchroniser depth
`define SYNC_STAGES 3

`endif

// ---- include/sbc_cfg_pkg.sv ----
// Purpose: shared types of the configuration register slice
// Assumes: constants live in sbc_cfg_consts.svh
// Notes: states carry no explicit codes
package sbc_cfg_pkg;

  typedef enum logic {
    DLY_WAIT,
    DLY_DONE
  } dly_state_type;

endpackage

// ---- design/pin_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter and rise pulse
// Assumes: pin is asynchronous to clk
// Notes: a change counts once stage two and stage three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin side
  input wire logic pinIn,
  // synchronous side
  output logic level,
  output logic rise
);

  logic meta_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;
  logic rise_q;

  // meta_q feeds stage2_q only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RESET_LEVEL;
      stage2_q <= RESET_LEVEL;
      stage3_q <= RESET_LEVEL;
    end else begin
      meta_q <= pinIn;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= RESET_LEVEL;
      rise_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      if (stage2_q == stage3_q && stage3_q != level_q) begin
        level_q <= stage3_q;
        rise_q <= stage3_q;
      end
    end
  end

  assign level = level_q;
  assign rise = rise_q;

endmodule // pin_sync

`default_nettype wire

// ---- design/sbc_config_lock_regs.sv ----
// Purpose: switching/lock control, pin function and duty registers over AXI4-Lite
// Assumes: rst_n is the supply power-on reset; restartEvt and cfgLock0 are same-clock
// Notes: byte address = 4 x register index; unmapped accesses answer SLVERR
// Notes on behaviour
// - level-0 lock blocks pin function writes
// - soft reset leaves locked bits untouched
// - level-1 lock freezes lockable switching bits
// - level-1 lock activates on chip-select rise
// - active lock bit frozen until power-on
// - frequency code 000..011, upper codes reserved
// - bit 4 selects high peak threshold
// - spread field: off or three rates
// - reserved bits always read zero
// - pin function codes decoded to modes
// - pin function kept on soft reset if locked
// - wake input is wake source in fail-safe
// - duty zero off, all ones on, else n/255
// - duty cleared on power-on/soft, kept restart
// - switching register kept on restart/soft reset
// - settings flagged valid (configValid) after extended reset delay
// - level-0 lock is input from neighbour register
`timescale 1ns/100ps
`default_nettype none
`include "sbc_cfg_consts.svh"

module sbc_config_lock_regs #(
  parameter int RESET_DELAY_CYCLES = `EXT_RESET_DELAY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // serial interface and chip state
  input wire logic chip_select_n,
  input wire logic cfgLock0,
  input wire logic restartEvt,
  input wire logic failSafeMode,
  // decoded switching settings
  output logic [2:0] switching_freq_sel,
  output logic freqReserved,
  output logic supply_peak_threshold_sel,
  output logic [1:0] spread_mod_rate,
  output logic lock1Active,
  output logic configValid,
  // decoded pin function
  output logic fail_output,
  output logic cyclicSenseSel,
  output logic pinOff,
  output logic wakeInputSel,
  output logic wakeSourceEn,
  output logic pwmLowSideOn,
  output logic pwmHighSideOn
);

  if (RESET_DELAY_CYCLES < 1) begin : gChk
    $error("RESET_DELAY_CYCLES must be at least one");
  end

  function automatic logic [5:0] regIdx(input logic [7:0] addr);
    regIdx = addr[7:2];
  endfunction

  function automatic logic isMapped(input logic [5:0] idx);
    isMapped = (idx == `IDX_SWITCH_LOCK) || (idx == `IDX_PIN_FUNC) ||
               (idx == `IDX_PWM_DUTY) || (idx == `IDX_SOFT_CTRL) || (idx == `IDX_STATUS);
  endfunction

  // register state
  logic [7:0] swLock_q;
  logic [2:0] pinFunc_q;
  logic [7:0] duty_q;
  logic lock1Active_q;

  // bus state
  logic awHeld_q;
  logic [7:0] awAddr_q;
  logic wHeld_q;
  logic [7:0] wData_q;
  logic wLane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // chip-select rise
  logic csRise;

  pin_sync #(
    .RESET_LEVEL(1'b1)
  ) uCsSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(chip_select_n),
    .level(),
    .rise(csRise)
  );

  // write channel: address and data taken in either order
  logic doWrite;
  logic [5:0] wIdx;
  logic wrSwLock;
  logic wrPinFunc;
  logic wrDuty;
  logic softRst;

  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign wIdx = regIdx(awAddr_q);
  assign wrSwLock = doWrite && wLane0_q && (wIdx == `IDX_SWITCH_LOCK);
  assign wrPinFunc = doWrite && wLane0_q && (wIdx == `IDX_PIN_FUNC);
  assign wrDuty = doWrite && wLane0_q && (wIdx == `IDX_PWM_DUTY);
  assign softRst = doWrite && wLane0_q && (wIdx == `IDX_SOFT_CTRL) &&
                   wData_q[`SOFT_RST_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
    end else if (awvalid && awready) begin
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wHeld_q <= 1'b0;
      wData_q <= 8'h00;
      wLane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld_q <= 1'b1;
      wData_q <= wdata[7:0];
      wLane0_q <= wstrb[0];
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (doWrite) begin
      bvalid_q <= 1'b1;
      bresp_q <= isMapped(wIdx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // switching and lock control: power-on value only, kept otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swLock_q <= `SWLK_POR;
    end else if (wrSwLock && !lock1Active_q) begin
      // frozen wholly once the lock is live, lock bit included
      swLock_q <= wData_q & `SWLK_WMASK;
    end
  end

  // lock goes live on the chip-select rise after the bit was written
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock1Active_q <= 1'b0;
    end else if (csRise && swLock_q[`LOCK1_BIT]) begin
      lock1Active_q <= 1'b1;
    end
  end

  // pin function: restart keeps the live mode, soft reset defaults unless locked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinFunc_q <= `PINF_POR;
    end else if (restartEvt) begin
      pinFunc_q <= pinFunc_q;
    end else if (softRst) begin
      if (!cfgLock0) begin
        pinFunc_q <= `PINF_POR;
      end
    end else if (wrPinFunc && !cfgLock0) begin
      // host must drop the level-0 lock first; locked writes vanish
      pinFunc_q <= wData_q[2:0];
    end
  end

  // duty: cleared by power-on and soft reset, kept over restart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duty_q <= `DUTY_POR;
    end else if (softRst) begin
      duty_q <= `DUTY_POR;
    end else if (wrDuty) begin
      duty_q <= wData_q;
    end
  end

  // extended reset delay after power-up or restart
  sbc_cfg_pkg::dly_state_type dlyState_q;
  logic [31:0] dlyCnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dlyState_q <= sbc_cfg_pkg::DLY_WAIT;
      dlyCnt_q <= 32'h00000000;
    end else if (restartEvt) begin
      dlyState_q <= sbc_cfg_pkg::DLY_WAIT;
      dlyCnt_q <= 32'h00000000;
    end else begin
      case (dlyState_q)
        sbc_cfg_pkg::DLY_WAIT: begin
          if (dlyCnt_q == 32'(RESET_DELAY_CYCLES - 1)) begin
            dlyState_q <= sbc_cfg_pkg::DLY_DONE;
          end else begin
            dlyCnt_q <= dlyCnt_q + 32'h00000001;
          end
        end
        sbc_cfg_pkg::DLY_DONE: begin
          dlyState_q <= sbc_cfg_pkg::DLY_DONE;
        end
        default: begin
          dlyState_q <= sbc_cfg_pkg::DLY_WAIT;
        end
      endcase
    end
  end

  // pwm: 255-step period, new duty taken at period end
  logic [7:0] pwmCnt_q;
  logic [7:0] dutyLive_q;
  logic pwmLevel_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwmCnt_q <= 8'h00;
      dutyLive_q <= `DUTY_POR;
    end else if (pwmCnt_q == `PWM_CNT_MAX) begin
      pwmCnt_q <= 8'h00;
      dutyLive_q <= duty_q;
    end else begin
      pwmCnt_q <= pwmCnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwmLevel_q <= 1'b0;
    end else begin
      pwmLevel_q <= (dutyLive_q == `DUTY_FULL) || (pwmCnt_q < dutyLive_q);
    end
  end

  // read channel, one cycle answer
  logic [5:0] rIdx;
  logic [7:0] rByte;

  assign rIdx = regIdx(araddr);
  assign arready = !rvalid_q;

  always_comb begin
    rByte = 8'h00;
    case (rIdx)
      `IDX_SWITCH_LOCK: rByte = swLock_q & `SWLK_WMASK;
      `IDX_PIN_FUNC: rByte = {5'h00, pinFunc_q};
      `IDX_PWM_DUTY: rByte = duty_q;
      `IDX_STATUS: begin
        rByte[`ST_LOCK1_BIT] = lock1Active_q;
        rByte[`ST_LOCK0_BIT] = cfgLock0;
        rByte[`ST_VALID_BIT] = (dlyState_q == sbc_cfg_pkg::DLY_DONE);
        rByte[`ST_FAILSAFE_BIT] = failSafeMode;
        rByte[`ST_PWM_BIT] = pwmLevel_q;
      end
      default: rByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rByte};
      rresp_q <= isMapped(rIdx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // decoded settings, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      switching_freq_sel <= 3'(`SWLK_POR >> `FREQ_LSB);
      freqReserved <= 1'b0;
      supply_peak_threshold_sel <= 1'b0;
      spread_mod_rate <= 2'h0;
      lock1Active <= 1'b0;
      configValid <= 1'b0;
    end else begin
      switching_freq_sel <= swLock_q[`FREQ_MSB:`FREQ_LSB];
      freqReserved <= swLock_q[`FREQ_RSVD_BIT];
      supply_peak_threshold_sel <= swLock_q[`PEAK_BIT];
      spread_mod_rate <= swLock_q[`SS_MSB:`SS_LSB];
      lock1Active <= lock1Active_q;
      configValid <= (dlyState_q == sbc_cfg_pkg::DLY_DONE);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fail_output <= 1'b1;
      cyclicSenseSel <= 1'b0;
      pinOff <= 1'b0;
      wakeInputSel <= 1'b0;
      wakeSourceEn <= 1'b0;
      pwmLowSideOn <= 1'b0;
      pwmHighSideOn <= 1'b0;
    end else begin
      fail_output <= (pinFunc_q <= `PF_FAIL_MAX);
      cyclicSenseSel <= (pinFunc_q == `PF_CYCLIC);
      pinOff <= (pinFunc_q == `PF_OFF);
      wakeInputSel <= (pinFunc_q == `PF_WAKE);
      wakeSourceEn <= (pinFunc_q == `PF_WAKE) && failSafeMode;
      pwmLowSideOn <= (pinFunc_q == `PF_PWM_LS) && pwmLevel_q;
      pwmHighSideOn <= (pinFunc_q == `PF_PWM_HS) && pwmLevel_q;
    end
  end

endmodule // sbc_config_lock_regs

`default_nettype wire

// ---- sim/sbc_config_lock_regs_assertions.sv ----
// Purpose: port checks of the configuration register slice
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the slice
`timescale 1ns/100ps
`default_nettype none
`include "sbc_cfg_consts.svh"

module sbc_cfg_lock_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  // chip state
  input wire logic chip_select_n,
  input wire logic restartEvt,
  input wire logic failSafeMode,
  // decoded outputs
  input wire logic [2:0] switching_freq_sel,
  input wire logic freqReserved,
  input wire logic supply_peak_threshold_sel,
  input wire logic [1:0] spread_mod_rate,
  input wire logic lock1Active,
  input wire logic configValid,
  input wire logic fail_output,
  input wire logic cyclicSenseSel,
  input wire logic pinOff,
  input wire logic wakeInputSel,
  input wire logic wakeSourceEn
);
  logic [7:0] arAddr_q;
  always_ff @(posedge clk) begin
    if (arvalid && arready) begin
      arAddr_q <= araddr;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_freqRsvd;
    freqReserved == (switching_freq_sel > 3'h3);
  endproperty
  a_freqRsvd: assert property (p_freqRsvd) else $error("reserved code flag wrong");
  property p_pinDecode;
    $onehot0({fail_output, cyclicSenseSel, pinOff, wakeInputSel});
  endproperty
  a_pinDecode: assert property (p_pinDecode) else $error("pin decode overlap");
  property p_wakeOn;
    wakeInputSel && $past(wakeInputSel) && failSafeMode && $past(failSafeMode) |-> wakeSourceEn;
  endproperty
  a_wakeOn: assert property (p_wakeOn) else $error("wake source missing");
  property p_wakeOff;
    wakeSourceEn |-> ($past(failSafeMode) || $past(failSafeMode, 2));
  endproperty
  a_wakeOff: assert property (p_wakeOff) else $error("wake source outside fail-safe");
  property p_lockHold;
    lock1Active |=> lock1Active;
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("lock released");
  property p_lockCause;
    $rose(lock1Active) |-> $past(chip_select_n) && !$past(chip_select_n, 8);
  endproperty
  a_lockCause: assert property (p_lockCause) else $error("lock without select rise");
  property p_freeze;
    lock1Active |=> $stable({switching_freq_sel, supply_peak_threshold_sel, spread_mod_rate});
  endproperty
  a_freeze: assert property (p_freeze) else $error("locked setting moved");
  property p_readZero;
    rvalid |-> rdata[31:8] == 24'h0 && (arAddr_q[7:2] != `IDX_SWITCH_LOCK || !rdata[1])
      && (arAddr_q[7:2] != `IDX_PIN_FUNC || rdata[7:3] == 5'h0);
  endproperty
  a_readZero: assert property (p_readZero) else $error("reserved bits not zero");
  property p_restart;
    restartEvt |-> ##[1:2] !configValid;
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted");
  c_lock: cover property ($rose(lock1Active));
  c_wake: cover property (wakeSourceEn);
  c_slverr: cover property (bvalid && bresp == `RESP_SLVERR);
endmodule // sbc_cfg_lock_checker

bind sbc_config_lock_regs sbc_cfg_lock_checker i_sbc_cfg_lock_checker (.*);
`default_nettype wire

// ---- sim/sbc_host_model.sv ----
// Purpose: host model making chip-select frames and the level-0 lock
// Assumes: one frame per request pulse
// Notes: lock level lands with the closing select edge
`timescale 1ns/100ps
`default_nettype none

module sbc_host_model (
  // clock and request
  input wire logic clk,
  input wire logic frameReq,
  input wire logic lock0Want,
  // serial side
  output logic chip_select_n,
  output logic cfgLock0
);
  initial begin
    chip_select_n = 1'b1;
    cfgLock0 = 1'b0;
    forever begin
      @(posedge clk);
      if (frameReq) begin
        chip_select_n <= 1'b0;
        repeat (8) @(posedge clk);
        // lock takes lock0Want at the close of its own frame, in the same step as the select rise
        cfgLock0 <= lock0Want;
        chip_select_n <= 1'b1;
      end
    end
  end
endmodule // sbc_host_model
`default_nettype wire

// ---- sim/sbc_config_lock_regs_bench.sv ----
// Purpose: self-checking bench of the configuration register slice
// Assumes: host model drives chip select and level-0 lock
// Notes: reset delay shortened to 6 cycles
`timescale 1ns/100ps
`default_nettype none
`include "sbc_cfg_consts.svh"

module sbc_config_lock_regs_bench;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_type;
  logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, restartEvt = 1'b0, failSafeMode = 1'b0;
  logic frameReq = 1'b0, lock0Want = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, br, rr, spread_mod_rate;
  logic [2:0] switching_freq_sel;
  logic awready, wready, bvalid, arready, rvalid, chip_select_n, cfgLock0, freqReserved;
  logic supply_peak_threshold_sel, lock1Active, configValid, fail_output, cyclicSenseSel;
  logic pinOff, wakeInputSel, wakeSourceEn, pwmLowSideOn, pwmHighSideOn;
  int nFail = 0, cmpCount = 0;
  row_type rows[16] = '{'{8'h3c, 8'h00, 8'h00}, '{8'h3c, 8'h26, 8'h24}, '{8'h3c, 8'he0, 8'he0},
    '{8'h3c, 8'h5a, 8'h58}, '{8'h3c, 8'h7c, 8'h7c}, '{8'h5c, 8'hf8, 8'h00},
    '{8'h5c, 8'hf9, 8'h01}, '{8'h5c, 8'hfa, 8'h02}, '{8'h5c, 8'hfb, 8'h03},
    '{8'h5c, 8'hfc, 8'h04}, '{8'h5c, 8'hfd, 8'h05}, '{8'h5c, 8'hfe, 8'h06},
    '{8'h5c, 8'hff, 8'h07}, '{8'h60, 8'ha5, 8'ha5}, '{8'h60, 8'hff, 8'hff},
    '{8'h80, 8'h5a, 8'h00}};

  sbc_config_lock_regs #(.RESET_DELAY_CYCLES(6)) i_sbc_config_lock_regs (
    .awprot(3'h0), .arprot(3'h0), .*);
  sbc_host_model i_sbc_host_model (.*);

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 60) begin
      nFail++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    logic aT, wT, bT;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aT = awvalid && awready;
      wT = wvalid && wready;
      bT = bvalid && bready;
      if (bT) br = bresp;
      @(posedge clk);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      if (bT) bready <= 1'b0;
      n++;
    end while ((awvalid || wvalid || bready) && n < 60);
    guard(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic aT, rT;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      aT = arvalid && arready;
      rT = rvalid && rready;
      if (rT) rv = rdata;
      if (rT) rr = rresp;
      @(posedge clk);
      if (aT) arvalid <= 1'b0;
      if (rT) rready <= 1'b0;
      n++;
    end while ((arvalid || rready) && n < 60);
    guard(n);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    cmp(rv, {24'h0, e});
  endtask
  task automatic frame(input logic l0);
    lock0Want <= l0;
    frameReq <= 1'b1;
    @(posedge clk);
    frameReq <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    int n;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(8'h3c, `SWLK_POR);
    chk(8'h5c, 8'h00);
    chk(8'h60, `DUTY_POR);
    cmp({switching_freq_sel, fail_output, lock1Active}, 5'b01010);
    done("reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk(rows[i].a, rows[i].r);
      cmp({br, rr}, (rows[i].a == 8'h80) ? 4'ha : 4'h0);
      n = rows[i].r;
      if (rows[i].a == 8'h3c) cmp({switching_freq_sel, supply_peak_threshold_sel,
        spread_mod_rate, freqReserved}, {rows[i].r[7:2], rows[i].r[7]});
      if (rows[i].a == 8'h5c) cmp({fail_output, cyclicSenseSel, pinOff, wakeInputSel},
        {n < 3, n == 3, n == 4, n == 5});
    end
    done("rows");
    wr(8'h5c, 8'h05);
    frame(1'b1);
    wr(8'h5c, 8'h07);
    chk(8'h5c, 8'h05);
    failSafeMode <= 1'b1;
    repeat (3) @(posedge clk);
    cmp(wakeSourceEn, 1'b1);
    failSafeMode <= 1'b0;
    wr(8'h60, 8'h33);
    wr(8'hc0, 8'h01);
    chk(8'h5c, 8'h05);
    chk(8'h60, 8'h00);
    chk(8'h3c, 8'h7c);
    frame(1'b0);
    wr(8'hc0, 8'h01);
    chk(8'h5c, 8'h00);
    done("lock0");
    wr(8'h60, 8'h33);
    restartEvt <= 1'b1;
    @(posedge clk);
    restartEvt <= 1'b0;
    repeat (3) @(posedge clk);
    cmp(configValid, 1'b0);
    n = 0;
    while (configValid !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    guard(n);
    @(posedge clk);
    cmp(configValid, 1'b1);
    chk(8'h60, 8'h33);
    done("restart");
    wr(8'h60, `DUTY_FULL);
    wr(8'h5c, 8'h07);
    repeat (520) @(posedge clk);
    cmp(pwmHighSideOn, 1'b1);
    wr(8'h60, 8'h80);
    repeat (520) @(posedge clk);
    n = 0;
    repeat (255) begin
      @(posedge clk);
      n += pwmHighSideOn;
    end
    cmp(n, 32'h80);
    wr(8'h5c, 8'h06);
    repeat (4) @(posedge clk);
    n = 0;
    repeat (255) begin
      @(posedge clk);
      n += pwmLowSideOn;
    end
    cmp(n, 32'h80);
    wr(8'h60, `DUTY_POR);
    repeat (520) @(posedge clk);
    cmp({pwmHighSideOn, pwmLowSideOn}, 2'b00);
    done("pwm");
    wr(8'h3c, 8'h25);
    cmp(lock1Active, 1'b0);
    frame(1'b0);
    n = 0;
    while (lock1Active !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    guard(n);
    @(posedge clk);
    cmp(lock1Active, 1'b1);
    wr(8'h3c, 8'h7c);
    chk(8'h3c, 8'h25);
    wr(8'hc0, 8'h01);
    chk(8'h3c, 8'h25);
    chk(8'hc4, (8'h01 << `ST_LOCK1_BIT) | (8'h01 << `ST_VALID_BIT));
    chk(8'hc0, 8'h00);
    done("lock1");
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp(lock1Active, 1'b0);
    chk(8'h3c, `SWLK_POR);
    wr(8'h3c, 8'h7c);
    chk(8'h3c, 8'h7c);
    done("power-on");
    give_verdict();
  end
endmodule // sbc_config_lock_regs_bench
`default_nettype wire
